// ---- hw/psl_strap_latch.v ----
/*
  Strap option latch: samples the shared strap pins at reset release and
  turns them into the power-on configuration, exposed through APB registers
  and configuration outputs.
  Assumes srst is synchronous to clk and held at least four cycles, so the
  synchronisers have settled before the release edge.
  A strap that moves within four cycles of release may be taken at either
  level, so the board must hold straps steady around it.
*/
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "psl_strap_defs.vh"

module psl_strap_latch
(
  // Clock and reset
  input  wire                     clk,
  input  wire                     srst,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [7:0]               paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  // Strap pins: input, output function, active-low output enable, pull enable
  input  wire [`PSL_NSTRAP-1:0]   strapIn,
  input  wire                     nandTreeIn_n,
  input  wire [`PSL_NSTRAP:0]     pinFuncOut,
  output reg  [`PSL_NSTRAP:0]     strapOut,
  output reg  [`PSL_NSTRAP:0]     strapOe_n,
  output reg                      strapPullEn,
  // Management address check
  input  wire                     mgmtReqValid,
  input  wire [4:0]               mgmtReqAddr,
  output reg                      mgmtAddrHit,
  output reg                      mgmtAddrBcast,
  // Latched configuration
  output reg  [4:0]               phyAddr,
  output reg  [2:0]               ifaceCfg,
  output reg                      ifaceRmii,
  output reg                      ifaceBackToBack,
  output reg                      ifaceCfgReserved,
  output reg                      addrZeroUnique,
  output reg                      nandTreeEn,
  output reg                      strapsLatched,
  // Live control bits
  output reg                      isolateEn,
  output reg                      speed100,
  output reg                      autonegEn,
  output reg                      duplexHalf
);

  wire [`PSL_NSTRAP:0] pinLevel;
  reg                  srstPrev;
  wire                 releaseEdge;
  reg  [15:0]          ctrlReg;
  reg  [15:0]          advReg;
  reg  [15:0]          statReg;
  reg  [15:0]          next_ctrlReg;
  reg  [15:0]          next_advReg;
  reg  [15:0]          rdWord;
  reg                  addrHit;
  wire                 apbAccess;
  wire                 apbWrite;

  // Straps pass the three-stage synchroniser; the nand-tree pin rides on top
  psl_sync uSync
  (
    .clk      (clk),
    .pinIn    ({nandTreeIn_n, strapIn}),
    .levelOut (pinLevel)
  );

  // Release is the first edge with srst low after it was high
  // No reset needed: it simply copies srst on every edge
  always @(posedge clk)
  begin
    srstPrev <= srst;
  end

  // One-cycle pulse, so a capture cannot repeat within one reset
  assign releaseEdge = srstPrev & ~srst;

  // Latched straps: defaults during reset, captured once at release, then frozen
  always @(posedge clk)
  begin
    if (srst)
    begin
      // Defaults follow the internal pulls, except ifaceCfg, which resets to RMII
      phyAddr          <= {`PSL_ADDR_HI, `PSL_ADDR_LO_RESET};
      ifaceCfg         <= `PSL_CFG_RMII;
      ifaceRmii        <= 1'h1;
      ifaceBackToBack  <= 1'h0;
      ifaceCfgReserved <= 1'h0;
      addrZeroUnique   <= 1'h0;
      nandTreeEn       <= ~`PSL_NAND_DEFAULT;
      strapsLatched    <= 1'h0;
    end
    else if (releaseEdge)
    begin
      // Upper address bits never come from pins
      phyAddr <= {`PSL_ADDR_HI, pinLevel[`PSL_PIN_ADDR2:`PSL_PIN_ADDR0]};
      ifaceCfg <= pinLevel[`PSL_PIN_CFG2:`PSL_PIN_CFG0];
      ifaceRmii <= (pinLevel[`PSL_PIN_CFG2:`PSL_PIN_CFG0] == `PSL_CFG_RMII);
      ifaceBackToBack <= (pinLevel[`PSL_PIN_CFG2:`PSL_PIN_CFG0] == `PSL_CFG_B2B);
      // Reserved patterns are flagged, the board must not use them
      ifaceCfgReserved <= (pinLevel[`PSL_PIN_CFG2:`PSL_PIN_CFG0] != `PSL_CFG_RMII)
                          && (pinLevel[`PSL_PIN_CFG2:`PSL_PIN_CFG0] != `PSL_CFG_B2B);
      addrZeroUnique <= pinLevel[`PSL_PIN_BCOFF];
      nandTreeEn <= ~pinLevel[`PSL_NSTRAP]; // Low strap enables test mode
      strapsLatched <= 1'h1;
    end
  end

  // Pins are inputs with pull while in reset and until capture, then drive
  always @(posedge clk)
  begin
    if (srst)
    begin
      // Pull stays on so an open strap reads its default
      strapOe_n   <= {(`PSL_NSTRAP+1){1'b1}};
      strapPullEn <= 1'h1;
      strapOut    <= {(`PSL_NSTRAP+1){1'b0}};
    end
    else
    begin
      // Hold off driving until the capture edge has passed
      strapOe_n   <= {(`PSL_NSTRAP+1){~(strapsLatched | releaseEdge)}};
      strapPullEn <= ~(strapsLatched | releaseEdge);
      strapOut    <= pinFuncOut;
    end
  end

  // Control and advertisement seeds from the pins at release
  always @*
  begin
    // Bits outside the writable set stay zero
    next_ctrlReg = 16'h0000;
    next_ctrlReg[`PSL_CTRL_SPEED]  = pinLevel[`PSL_PIN_SPEED];
    next_ctrlReg[`PSL_CTRL_ANEG]   = pinLevel[`PSL_PIN_ANEG];
    next_ctrlReg[`PSL_CTRL_ISO]    = pinLevel[`PSL_PIN_ISO];
    next_ctrlReg[`PSL_CTRL_DUPLEX] = pinLevel[`PSL_PIN_DUPLEX];
    // 10 Mbps strap withdraws the 100 Mbps abilities from the advertisement
    if (pinLevel[`PSL_PIN_SPEED])
    begin
      next_advReg = `PSL_ADV_BASE | `PSL_ADV_10_CAPS | `PSL_ADV_100_CAPS;
    end
    else
    begin
      next_advReg = `PSL_ADV_BASE | `PSL_ADV_10_CAPS;
    end
  end

  assign apbAccess = psel & penable & pready;
  assign apbWrite  = apbAccess & pwrite;

  // Registers: defaults in reset, strap seed at release, then software owns them
  always @(posedge clk)
  begin
    if (srst)
    begin
      // Pull defaults, in case software reads before release
      ctrlReg <= `PSL_CTRL_RESET;
      advReg  <= `PSL_ADV_BASE | `PSL_ADV_10_CAPS | `PSL_ADV_100_CAPS;
    end
    else if (releaseEdge)
    begin
      ctrlReg <= next_ctrlReg;
      advReg  <= next_advReg;
    end
    else if (apbWrite)
    begin
      if (paddr == `PSL_OFS_CTRL)
      begin
        ctrlReg <= pwdata[15:0] & `PSL_CTRL_WMASK;
      end
      else if (paddr == `PSL_OFS_ADV)
      begin
        advReg <= (pwdata[15:0] & `PSL_ADV_WMASK) | `PSL_ADV_BASE;
      end
    end
  end

  // Live control outputs follow the control register
  // One cycle behind ctrlReg, so a software write shows a cycle later
  always @(posedge clk)
  begin
    if (srst)
    begin
      isolateEn  <= 1'h0;
      speed100   <= 1'h1;
      autonegEn  <= 1'h1;
      duplexHalf <= 1'h1;
    end
    else
    begin
      isolateEn  <= ctrlReg[`PSL_CTRL_ISO];
      speed100   <= ctrlReg[`PSL_CTRL_SPEED];
      autonegEn  <= ctrlReg[`PSL_CTRL_ANEG];
      duplexHalf <= ctrlReg[`PSL_CTRL_DUPLEX];
    end
  end

  // Status word shows the latched strap state
  always @*
  begin
    // Read-only; a write here is refused on the bus
    statReg = 16'h0000;
    statReg[`PSL_STAT_ADDR_MSB:`PSL_STAT_ADDR_LSB] = phyAddr;
    statReg[`PSL_STAT_CFG_MSB:`PSL_STAT_CFG_LSB]   = ifaceCfg;
    statReg[`PSL_STAT_RSVD]    = ifaceCfgReserved;
    statReg[`PSL_STAT_UNIQUE]  = addrZeroUnique;
    statReg[`PSL_STAT_NAND]    = nandTreeEn;
    statReg[`PSL_STAT_LATCHED] = strapsLatched;
  end

  // Read mux; unmapped offsets read zero and raise an error
  always @*
  begin
    if (paddr == `PSL_OFS_CTRL)
    begin
      rdWord = ctrlReg;
    end
    else if (paddr == `PSL_OFS_ADV)
    begin
      rdWord = advReg;
    end
    else if (paddr == `PSL_OFS_STAT)
    begin
      rdWord = statReg;
    end
    else
    begin
      rdWord = 16'h0000;
    end
  end

  // APB answer: one wait state, pready raised in the second access cycle
  always @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      // Raised with pready so the master sees both at one edge
      pslverr <= psel & penable & ~pready & (paddr != `PSL_OFS_CTRL)
                 & (paddr != `PSL_OFS_ADV) & ~((paddr == `PSL_OFS_STAT) & ~pwrite);
      if (psel & penable & ~pready & ~pwrite)
      begin
        prdata <= {16'h0000, rdWord};
      end
      else if (apbAccess)
      begin
        prdata <= 32'h00000000; // Do not leave stale read data standing
      end
    end
  end

  // Address match: own address, or zero as broadcast unless made unique
  always @*
  begin
    // Requests with bits 4:3 set never match, as ours are fixed
    addrHit = (mgmtReqAddr == phyAddr);
    if ((mgmtReqAddr == `PSL_ADDR_ZERO) && !addrZeroUnique)
    begin
      addrHit = 1'b1;
    end
  end

  // Registered match result; broadcast flag marks a zero hit that is not unique
  always @(posedge clk)
  begin
    if (srst)
    begin
      mgmtAddrHit   <= 1'h0;
      mgmtAddrBcast <= 1'h0;
    end
    else
    begin
      mgmtAddrHit   <= mgmtReqValid & addrHit;
      mgmtAddrBcast <= mgmtReqValid & (mgmtReqAddr == `PSL_ADDR_ZERO) & ~addrZeroUnique;
    end
  end

endmodule

// ---- hw/psl_sync.v ----
/*
  Three-stage synchroniser bank for the strap pins, one chain per bit.
  A level is accepted once the second and third stages agree.
  Assumes pins are asynchronous to clk; no reset, so it tracks during reset.
*/
`timescale 1ns/1ps
`include "psl_strap_defs.vh"

module psl_sync
(
  // Clock
  input  wire                     clk,
  // Raw pin levels
  input  wire [`PSL_NSTRAP:0]     pinIn,
  // Filtered levels
  output wire [`PSL_NSTRAP:0]     levelOut
);

  genvar i;

  generate
    for (i = 0; i <= `PSL_NSTRAP; i = i + 1)
    begin : gChain
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;

      // First stage feeds only the second, to keep metastability contained
      always @(posedge clk)
      begin
        stage1 <= pinIn[i];
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3)
        begin
          level <= stage3; // Change counts once two stages agree
        end
      end

      // One driver per bit keeps the bank free of shared drivers
      assign levelOut[i] = level;
    end
  endgenerate

endmodule

// ---- pkg/psl_strap_defs.vh ----
/*
  Constants for the strap option latch: pin positions in the strap bus,
  register offsets and field positions, reset values and strap defaults.
  Assumes it is included by bare name from every design file of the block.
*/
`ifndef PSL_STRAP_DEFS_VH
`define PSL_STRAP_DEFS_VH

// Strap bus width and bit positions
`define PSL_NSTRAP          11
`define PSL_PIN_ADDR0       0
`define PSL_PIN_ADDR2       2
`define PSL_PIN_CFG0        3
`define PSL_PIN_CFG2        5
`define PSL_PIN_ISO         6
`define PSL_PIN_SPEED       7
`define PSL_PIN_DUPLEX      8
`define PSL_PIN_ANEG        9
`define PSL_PIN_BCOFF       10

// Strap defaults as the internal pulls leave them (nand-tree pin has its own)
`define PSL_STRAP_DEFAULT   11'h381
`define PSL_NAND_DEFAULT    1'h1

// Management address bits 4:3 are fixed inside, never strapped
`define PSL_ADDR_HI         2'h0
`define PSL_ADDR_ZERO       5'h00

// Reset values of the control register and the low address bits
`define PSL_CTRL_RESET      16'h3100
`define PSL_ADDR_LO_RESET   3'h1

// Interface configuration patterns
`define PSL_CFG_RMII        3'h1
`define PSL_CFG_B2B         3'h5

// APB register byte offsets
`define PSL_OFS_CTRL        8'h00
`define PSL_OFS_ADV         8'h04
`define PSL_OFS_STAT        8'h08

// Control register field positions and writable mask
`define PSL_CTRL_SPEED      13
`define PSL_CTRL_ANEG       12
`define PSL_CTRL_ISO        10
`define PSL_CTRL_DUPLEX     8
`define PSL_CTRL_WMASK      16'h3500

// Advertisement register: selector field and speed capability bits
`define PSL_ADV_BASE        16'h0001
`define PSL_ADV_10_CAPS     16'h0060
`define PSL_ADV_100_CAPS    16'h0180
`define PSL_ADV_WMASK       16'h01e0

// Status register field positions
`define PSL_STAT_ADDR_LSB   0
`define PSL_STAT_ADDR_MSB   4
`define PSL_STAT_CFG_LSB    5
`define PSL_STAT_CFG_MSB    7
`define PSL_STAT_RSVD       8
`define PSL_STAT_UNIQUE     9
`define PSL_STAT_NAND       10
`define PSL_STAT_LATCHED    11

`endif

// ---- verif/psl_strap_board.sv ----
/*
  Board side of the strap pins: pull resistors hold each pin at the
  strapped level until the device takes the pin over.
  Assumes strapOe_n is active low and bit 11 is the nand-tree pin.
*/
`timescale 1ns/1ps
`include "psl_strap_defs.vh"
module psl_strap_board
(
  // Strap pattern fitted on the board
  input  wire [`PSL_NSTRAP:0]   pullLevel,
  // Device drive
  input  wire [`PSL_NSTRAP:0]   strapOut,
  input  wire [`PSL_NSTRAP:0]   strapOe_n,
  // Pin levels seen by the device
  output wire [`PSL_NSTRAP-1:0] strapIn,
  output wire                   nandTreeIn_n
);
  wire [`PSL_NSTRAP:0] pinLevel;
  // Device drive wins; otherwise the pull sets the level
  assign pinLevel     = (strapOut & ~strapOe_n) | (pullLevel & strapOe_n);
  assign strapIn      = pinLevel[`PSL_NSTRAP-1:0];
  assign nandTreeIn_n = pinLevel[`PSL_NSTRAP];
endmodule

// ---- verif/psl_strap_latch_test.sv ----
/*
  Bench for the strap latch: walks every interface pattern through a
  reset, reads the result over APB and checks the address match.
  Assumes no fixed APB latency: the master waits for pready each time.
*/
`timescale 1ns/1ps
`include "psl_strap_defs.vh"
module psl_strap_latch_test;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [11:0] pat = 12'h000, pinFunc = 12'h000;
  reg         mgmtReqValid = 1'b0;
  reg  [4:0]  mgmtReqAddr = 5'h00;
  wire [31:0] prdata;
  wire        pready, pslverr, nandTreeIn_n, strapPullEn, hit, bcast;
  wire [10:0] strapIn;
  wire [11:0] strapOut, strapOe_n;
  reg  [31:0] rd;
  reg         er;
  integer     nFail = 0, testsRun = 0, cyc = 0, i;
  initial forever #50 clk = ~clk;
  psl_strap_board psl_strap_board_inst (.pullLevel(pat), .strapOut(strapOut),
    .strapOe_n(strapOe_n), .strapIn(strapIn), .nandTreeIn_n(nandTreeIn_n));
  psl_strap_latch psl_strap_latch_inst (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strapIn(strapIn), .nandTreeIn_n(nandTreeIn_n),
    .pinFuncOut(pinFunc), .strapOut(strapOut), .strapOe_n(strapOe_n),
    .strapPullEn(strapPullEn), .mgmtReqValid(mgmtReqValid), .mgmtReqAddr(mgmtReqAddr),
    .mgmtAddrHit(hit), .mgmtAddrBcast(bcast), .phyAddr(), .ifaceCfg(), .ifaceRmii(),
    .ifaceBackToBack(), .ifaceCfgReserved(), .addrZeroUnique(), .nandTreeEn(),
    .strapsLatched(), .isolateEn(), .speed100(), .autonegEn(), .duplexHalf());
  task giveVerdict;
  begin
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    testsRun = testsRun + 1;
    if (seen !== exp)
    begin
      nFail = nFail + 1;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One APB transfer; pready, read data and error looked at once settled
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    rd = prdata;
    er = pslverr;
    // Request held through the edge that takes it, then released
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // Request sampled at one edge, result looked at in the cycle after
  task addrCheck(input [4:0] a, input [1:0] exp);
  begin
    @(posedge clk);
    mgmtReqValid <= 1'b1;
    mgmtReqAddr <= a;
    @(posedge clk);
    mgmtReqValid <= 1'b0;
    #1;
    check({hit, bcast}, exp);
  end
  endtask
  // Cycle ceiling guards against a hung handshake
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc > 20000)
    begin
      nFail = nFail + 1;
      giveVerdict;
    end
  end
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      // Strap word: nand, unique, aneg, duplex, speed, iso, cfg, addr
      pat <= {i[0] ^ i[2], i[1] ^ i[2], ~i[0], i[2], i[1], i[0], i[2:0], i[2:0]};
      pinFunc <= 12'h000;
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, `PSL_OFS_STAT, 32'h0);
      check(rd, {20'h0, 1'b1, ~pat[11], pat[10], (i != 1 && i != 5), i[2:0], 2'b00,
        i[2:0]});
      apb(1'b0, `PSL_OFS_CTRL, 32'h0);
      check(rd, {18'h0, pat[7], pat[9], 1'b0, pat[6], 1'b0, pat[8], 8'h00});
      apb(1'b0, `PSL_OFS_ADV, 32'h0);
      check(rd, pat[7] ? 32'h01e1 : 32'h0061);
      addrCheck(5'h00, pat[10] ? {i == 0, 1'b0} : 2'b11);
      addrCheck(i[4:0], {1'b1, i == 0 && !pat[10]});
      addrCheck({2'b11, i[2:0]}, 2'b00);
      // Device drives pins inverted; the latch must not follow
      pinFunc <= ~pat;
      repeat (6) @(posedge clk);
      check({strapOut, strapOe_n, 7'h0, strapPullEn}, {~pat, 12'h000, 8'h00});
      apb(1'b0, `PSL_OFS_STAT, 32'h0);
      check(rd[10:0], {~pat[11], pat[10], (i != 1 && i != 5), i[2:0], 2'b00, i[2:0]});
    end
    // Writable masks, read-only status and an unmapped place
    apb(1'b1, `PSL_OFS_CTRL, 32'hffffffff);
    apb(1'b0, `PSL_OFS_CTRL, 32'h0);
    check(rd, {16'h0, `PSL_CTRL_WMASK});
    apb(1'b1, `PSL_OFS_ADV, 32'h0);
    apb(1'b0, `PSL_OFS_ADV, 32'h0);
    check(rd, {16'h0, `PSL_ADV_BASE});
    apb(1'b1, `PSL_OFS_STAT, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], er}, 32'h1);
    giveVerdict;
  end
endmodule

// ---- verif/psl_strap_sva.sv ----
/*
  Assertions on the strap latch ports.
  Assumes the board holds the straps steady around the capture edge.
*/
`timescale 1ns/1ps
`include "psl_strap_defs.vh"
module psl_strap_sva
(
  // Clock and reset
  input wire                   clk,
  input wire                   srst,
  // Pins
  input wire [`PSL_NSTRAP-1:0] strapIn,
  input wire                   nandTreeIn_n,
  input wire [`PSL_NSTRAP:0]   strapOe_n,
  input wire                   strapPullEn,
  // Address check
  input wire                   mgmtReqValid,
  input wire [4:0]             mgmtReqAddr,
  input wire                   mgmtAddrHit,
  input wire                   mgmtAddrBcast,
  // Latched configuration and live control bits
  input wire [4:0]             phyAddr,
  input wire [2:0]             ifaceCfg,
  input wire                   ifaceRmii,
  input wire                   ifaceBackToBack,
  input wire                   ifaceCfgReserved,
  input wire                   addrZeroUnique,
  input wire                   nandTreeEn,
  input wire                   strapsLatched,
  input wire                   isolateEn,
  input wire                   speed100,
  input wire                   autonegEn,
  input wire                   duplexHalf
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  // Capture edge values, then what must hold afterwards
  AST_ADDR_LOW: assert property ($rose(strapsLatched) |->
    phyAddr[2:0] == $past(strapIn[2:0]))
    else $error("address straps not captured");
  AST_ADDR_HI: assert property (phyAddr[4:3] == `PSL_ADDR_HI)
    else $error("address high bits not fixed");
  AST_CFG: assert property ($rose(strapsLatched) |->
    ifaceCfg == $past(strapIn[5:3])
    && ifaceRmii == (ifaceCfg == `PSL_CFG_RMII) && ifaceBackToBack == (ifaceCfg == `PSL_CFG_B2B)
    && ifaceCfgReserved == !(ifaceRmii || ifaceBackToBack))
    else $error("interface config wrong");
  AST_CTRL: assert property ($rose(strapsLatched) |=>
    isolateEn == $past(strapIn[6], 2)
    && speed100 == $past(strapIn[7], 2) && duplexHalf == $past(strapIn[8], 2)
    && autonegEn == $past(strapIn[9], 2))
    else $error("control bits not seeded");
  AST_LATCH: assert property ($rose(strapsLatched) |->
    addrZeroUnique == $past(strapIn[10])
    && nandTreeEn == !$past(nandTreeIn_n))
    else $error("mode straps not captured");
  AST_HOLD: assert property (strapsLatched && $past(strapsLatched) |->
    $stable(phyAddr)
    && $stable(ifaceCfg) && $stable(addrZeroUnique) && $stable(nandTreeEn))
    else $error("latched value moved");
  AST_PINS: assert property (strapsLatched |=>
    strapOe_n == 12'h000 && !strapPullEn)
    else $error("pins not released to output");
  AST_PULL: assert property (!strapsLatched |->
    strapPullEn && strapOe_n == 12'hfff)
    else $error("pins not pulled before capture");
  AST_HIT: assert property ($past(strapsLatched) |->
    mgmtAddrHit == ($past(mgmtReqValid)
    && ($past(mgmtReqAddr) == $past(phyAddr)
    || ($past(mgmtReqAddr) == `PSL_ADDR_ZERO && !$past(addrZeroUnique)))))
    else $error("address hit wrong");
  AST_BCAST: assert property ($past(strapsLatched) |->
    mgmtAddrBcast == ($past(mgmtReqValid)
    && $past(mgmtReqAddr) == `PSL_ADDR_ZERO && !$past(addrZeroUnique)))
    else $error("broadcast flag wrong");
endmodule
bind psl_strap_latch psl_strap_sva psl_strap_sva_inst (.clk, .srst, .strapIn, .nandTreeIn_n,
  .strapOe_n, .strapPullEn, .mgmtReqValid, .mgmtReqAddr, .mgmtAddrHit, .mgmtAddrBcast,
  .phyAddr, .ifaceCfg, .ifaceRmii, .ifaceBackToBack, .ifaceCfgReserved, .addrZeroUnique,
  .nandTreeEn, .strapsLatched, .isolateEn, .speed100, .autonegEn, .duplexHalf);
